// ### logic/rmdt_pkg.sv
// Purpose: shared constants and types for the rest mode downshift timing block
// Assumes: core clock of 100 MHz; 7-bit register addresses on the serial port
// Notes: crc result offsets are placed in free register space
package rmdt_pkg;
  // ==========================================================
  // register map
  localparam logic [6:0] ADDR_FW_ENABLE = 7'h13;
  localparam logic [6:0] ADDR_RUN_DELAY = 7'h14;
  localparam logic [6:0] ADDR_FIRST_LOW_POWER_STATE_FRAME_INTERVAL = 7'h15;
  localparam logic [6:0] ADDR_FIRST_LOW_POWER_STATE_DELAY = 7'h16;
  localparam logic [6:0] ADDR_SECOND_LOW_POWER_STATE_FRAME_INTERVAL = 7'h17;
  localparam logic [6:0] ADDR_SECOND_LOW_POWER_STATE_DELAY = 7'h18;
  localparam logic [6:0] ADDR_THIRD_LOW_POWER_STATE_FRAME_INTERVAL = 7'h19;
  localparam logic [6:0] ADDR_PERIOD_LOW = 7'h1A;
  localparam logic [6:0] ADDR_PERIOD_HIGH = 7'h1B;
  localparam logic [6:0] ADDR_CRC_LOW = 7'h25;
  localparam logic [6:0] ADDR_CRC_HIGH = 7'h26;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_RUN_DELAY = 8'h32;
  localparam logic [7:0] RST_FIRST_LOW_POWER_STATE_FRAME_INTERVAL = 8'h01;
  localparam logic [7:0] RST_FIRST_LOW_POWER_STATE_DELAY = 8'h1F;
  localparam logic [7:0] RST_SECOND_LOW_POWER_STATE_FRAME_INTERVAL = 8'h09;
  localparam logic [7:0] RST_SECOND_LOW_POWER_STATE_DELAY = 8'hBC;
  localparam logic [7:0] RST_THIRD_LOW_POWER_STATE_FRAME_INTERVAL = 8'h31;
  localparam logic [7:0] RST_PERIOD_LOW = 8'hC0;
  localparam logic [7:0] RST_PERIOD_HIGH = 8'h5D;
  localparam logic [7:0] RD_ZERO = 8'h00;
  // ==========================================================
  // codes, fields and timing
  localparam logic [7:0] CRC_START_CODE = 8'h15;
  localparam int SPI_WRITE_BIT = 7;
  localparam int FIRST_LOW_POWER_STATE_SHIFT = 4;           // downshift counts 16 frames per step
  localparam int SECOND_LOW_POWER_STATE_SHIFT = 5;           // downshift counts 32 frames per step
  localparam int CLK_MHZ = 100;
  localparam int OSC_MHZ = 50;
  localparam int OSC_DIV = CLK_MHZ / OSC_MHZ;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  localparam logic [1:0] SETTLE_FRAMES = 2'h2;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    RUN_STATE,
    FIRST_LOW_POWER,
    SECOND_LOW_POWER,
    THIRD_LOW_POWER
  } rmdt_mode_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } rmdt_req_t;
endpackage

// ### logic/rmdt_spi_port.sv
// Purpose: serial register port, sampled on the core clock
// Assumes: sclk idles high, data in on rising edge, out on falling edge
// Notes: sclk half period must be at least four core cycles
`timescale 1ns/100ps
`default_nettype none
module rmdt_spi_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // serial pins
  input wire logic ncs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // register side
  output rmdt_pkg::rmdt_req_t req,
  input wire logic [7:0] rdata
);
  import rmdt_pkg::*;
  logic cs_s1, cs_s2, sck_s1, sck_s2, sck_d, mosi_s1, mosi_s2;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic [7:0] tx_shift;
  logic addr_done, is_write;
  // ==========================================================
  // decode of synchronised pins
  wire active = ~cs_s2;
  wire rise = active & sck_s2 & ~sck_d;
  wire fall = active & ~sck_s2 & sck_d;
  wire [7:0] next_byte = {shift, mosi_s2};
  wire byte_done = rise & (bit_cnt == 3'h7);

  // two-stage synchronisers, third stage for edge detection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {cs_s1, cs_s2, sck_s1, sck_s2, sck_d} <= 5'h1F;
      {mosi_s1, mosi_s2} <= 2'h0;
    end else if (clk_en) begin
      {cs_s1, cs_s2} <= {ncs_n, cs_s1};
      {sck_s1, sck_s2, sck_d} <= {sclk, sck_s1, sck_s2};
      {mosi_s1, mosi_s2} <= {mosi, mosi_s1};
    end
  end

  // byte assembly and request pulses
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      addr_done <= 1'b0;
      is_write <= 1'b0;
      req <= '0;
    end else if (clk_en) begin
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      if (!active) begin
        bit_cnt <= 3'h0;
        addr_done <= 1'b0;
      end else if (rise) begin
        shift <= next_byte[6:0];
        bit_cnt <= bit_cnt + 3'h1;
        if (byte_done && !addr_done) begin
          addr_done <= 1'b1;
          is_write <= next_byte[SPI_WRITE_BIT];
          req.addr <= next_byte[6:0];
          req.rd <= ~next_byte[SPI_WRITE_BIT];
        end else if (byte_done && is_write) begin
          req.wdata <= next_byte;
          req.wr <= 1'b1;
        end
      end
    end
  end

  // read data shifted out msb first on falling edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift <= 8'h00;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else if (clk_en) begin
      miso_oe <= active;
      if (req.rd) tx_shift <= rdata;
      else if (fall && addr_done && !is_write) begin
        miso <= tx_shift[7];
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end
endmodule // rmdt_spi_port
`default_nettype wire

// ### logic/rmdt_top.sv
// Behaviour
// - writing 0x15 to firmware enable starts crc
// - finished crc readable in low/high result
// - crc halts tracking; host stays off port
// - run to first_low_power_state after delay times 10ms
// - run delay timed from system clock
// - first_low_power_state frame every (rate+1) times 10ms
// - first_low_power_state to second_low_power_state after delay*16 frames
// - second_low_power_state frame every (rate+1) times 10ms
// - second_low_power_state to third_low_power_state after delay*32 frames
// - third_low_power_state frame every (rate+1) times 10ms
// - rest timing from hibernate 10ms tick
// - period bound limits auto, sets manual
// - bound counts 50 MHz oscillator cycles
// - upper bound byte write activates at once, settling flag held for two frames
// - rest steps down in order, motion wakes
// - fixed rate takes period from bound
//
// Purpose: run/rest mode timing, frame period bound and firmware crc test
// Assumes: motion and firmware memory on core_clk; memory data one cycle late
// Notes: register writes ignored while the crc test runs
`timescale 1ns/100ps
`default_nettype none
module rmdt_top #(
  parameter int SYS_TICK_CYCLES = rmdt_pkg::TICK_CYCLES,
  parameter int HIB_TICK_CYCLES = rmdt_pkg::TICK_CYCLES,
  parameter int FW_BYTES = 4096,
  parameter logic [15:0] CRC_POLY = 16'h1021,
  parameter logic [15:0] CRC_INIT = 16'h0000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // serial pins
  input wire logic ncs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // tracking side
  input wire logic motion_seen,
  input wire logic rest_enable,
  input wire logic fixed_frame_rate_sel,
  input wire logic [15:0] auto_frame_period,
  output rmdt_pkg::rmdt_mode_t op_mode,
  output logic frame_strobe,
  output logic [15:0] frame_period,
  output logic bound_settling,
  output logic tracking_halt,
  // firmware memory
  output logic [15:0] fw_addr,
  output logic fw_rd,
  input wire logic [7:0] fw_data
);
  import rmdt_pkg::*;
  localparam int SYS_W = $clog2(SYS_TICK_CYCLES + 1);
  localparam int HIB_W = $clog2(HIB_TICK_CYCLES + 1);
  localparam int OSC_W = $clog2(OSC_DIV + 1);
  if (SYS_TICK_CYCLES < 1 || HIB_TICK_CYCLES < 1 || FW_BYTES < 1 || FW_BYTES > 65536)
  begin : bad_cfg
    $error("rmdt_top: tick counts or firmware size out of range");
  end

  // ==========================================================
  // reset release and register port
  logic [1:0] rst_sync;
  wire rst_n = rst_sync[1];
  rmdt_req_t req;
  logic [7:0] rdata;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) rst_sync <= 2'h0;
    else if (clk_en) rst_sync <= {rst_sync[0], 1'b1};
  end
  rmdt_spi_port u_port (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .ncs_n(ncs_n), .sclk(sclk), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .req(req), .rdata(rdata)
  );

  // ==========================================================
  // register file
  logic [7:0] run_to_first_low_power_state_delay, first_low_power_state_frame_interval, first_low_power_state_to_second_low_power_state_delay;
  logic [7:0] second_low_power_state_frame_interval, second_low_power_state_to_third_low_power_state_delay, third_low_power_state_frame_interval;
  logic [7:0] longest_frame_period_low, longest_frame_period_high, low_shadow;
  logic [15:0] active_bound, crc_result, crc_acc;
  logic crc_busy;
  logic [1:0] settle_cnt;
  wire wr_ok = req.wr & ~crc_busy;
  wire crc_start = wr_ok & (req.addr == ADDR_FW_ENABLE) & (req.wdata == CRC_START_CODE);
  wire high_wr = wr_ok & (req.addr == ADDR_PERIOD_HIGH);

  // read data select; low byte of bound read from the shadow
  assign rdata =
    (req.addr == ADDR_RUN_DELAY) ? run_to_first_low_power_state_delay :
    (req.addr == ADDR_FIRST_LOW_POWER_STATE_FRAME_INTERVAL) ? first_low_power_state_frame_interval :
    (req.addr == ADDR_FIRST_LOW_POWER_STATE_DELAY) ? first_low_power_state_to_second_low_power_state_delay :
    (req.addr == ADDR_SECOND_LOW_POWER_STATE_FRAME_INTERVAL) ? second_low_power_state_frame_interval :
    (req.addr == ADDR_SECOND_LOW_POWER_STATE_DELAY) ? second_low_power_state_to_third_low_power_state_delay :
    (req.addr == ADDR_THIRD_LOW_POWER_STATE_FRAME_INTERVAL) ? third_low_power_state_frame_interval :
    (req.addr == ADDR_PERIOD_LOW) ? low_shadow :
    (req.addr == ADDR_PERIOD_HIGH) ? longest_frame_period_high :
    (req.addr == ADDR_CRC_LOW) ? crc_result[7:0] :
    (req.addr == ADDR_CRC_HIGH) ? crc_result[15:8] : RD_ZERO;

  // register writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_to_first_low_power_state_delay <= RST_RUN_DELAY;
      first_low_power_state_frame_interval <= RST_FIRST_LOW_POWER_STATE_FRAME_INTERVAL;
      first_low_power_state_to_second_low_power_state_delay <= RST_FIRST_LOW_POWER_STATE_DELAY;
      second_low_power_state_frame_interval <= RST_SECOND_LOW_POWER_STATE_FRAME_INTERVAL;
      second_low_power_state_to_third_low_power_state_delay <= RST_SECOND_LOW_POWER_STATE_DELAY;
      third_low_power_state_frame_interval <= RST_THIRD_LOW_POWER_STATE_FRAME_INTERVAL;
      longest_frame_period_low <= RST_PERIOD_LOW;
      longest_frame_period_high <= RST_PERIOD_HIGH;
    end else if (clk_en && wr_ok) begin
      unique case (req.addr)
        ADDR_RUN_DELAY: run_to_first_low_power_state_delay <= req.wdata;
        ADDR_FIRST_LOW_POWER_STATE_FRAME_INTERVAL: first_low_power_state_frame_interval <= req.wdata;
        ADDR_FIRST_LOW_POWER_STATE_DELAY: first_low_power_state_to_second_low_power_state_delay <= req.wdata;
        ADDR_SECOND_LOW_POWER_STATE_FRAME_INTERVAL: second_low_power_state_frame_interval <= req.wdata;
        ADDR_SECOND_LOW_POWER_STATE_DELAY: second_low_power_state_to_third_low_power_state_delay <= req.wdata;
        ADDR_THIRD_LOW_POWER_STATE_FRAME_INTERVAL: third_low_power_state_frame_interval <= req.wdata;
        ADDR_PERIOD_LOW: longest_frame_period_low <= req.wdata;
        ADDR_PERIOD_HIGH: longest_frame_period_high <= req.wdata;
        default: ;
      endcase
    end
  end

  // bound activation on upper write, settle over two frames, read shadow
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_bound <= {RST_PERIOD_HIGH, RST_PERIOD_LOW};
      low_shadow <= RST_PERIOD_LOW;
      settle_cnt <= 2'h0;
    end else if (clk_en) begin
      if (high_wr) active_bound <= {req.wdata, longest_frame_period_low};
      if (high_wr) settle_cnt <= SETTLE_FRAMES;
      else if (frame_strobe && settle_cnt != 2'h0) settle_cnt <= settle_cnt - 2'h1;
      if (req.rd && req.addr == ADDR_PERIOD_HIGH) low_shadow <= longest_frame_period_low;
      else if (wr_ok && req.addr == ADDR_PERIOD_LOW) low_shadow <= req.wdata;
    end
  end

  // ==========================================================
  // firmware crc self-test
  logic [15:0] fw_idx;
  logic fw_valid;
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction
  wire [15:0] crc_next = crc_byte(crc_acc, fw_data);
  wire fw_last = (fw_idx == 16'(FW_BYTES - 1));

  // walk the memory, fold each byte, publish at the end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_busy <= 1'b0;
      crc_acc <= 16'h0000;
      crc_result <= 16'h0000;
      fw_idx <= 16'h0000;
      fw_addr <= 16'h0000;
      fw_rd <= 1'b0;
      fw_valid <= 1'b0;
      tracking_halt <= 1'b0;
    end else if (clk_en) begin
      fw_valid <= fw_rd;
      if (crc_start) begin
        crc_busy <= 1'b1;
        tracking_halt <= 1'b1;
        crc_acc <= CRC_INIT;
        fw_idx <= 16'h0000;
        fw_addr <= 16'h0000;
        fw_rd <= 1'b1;
      end else if (crc_busy) begin
        if (fw_rd && !fw_last) fw_idx <= fw_idx + 16'h0001;
        fw_addr <= fw_last ? fw_addr : fw_idx + 16'h0001;
        fw_rd <= fw_rd & ~fw_last;
        if (fw_valid) crc_acc <= crc_next;
        if (fw_valid && !fw_rd) begin
          crc_result <= crc_next;
          crc_busy <= 1'b0;
          tracking_halt <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // tick prescalers: system ticks for run, hibernate ticks for rest
  rmdt_mode_t mode, next_mode;
  logic [SYS_W-1:0] sys_pre;
  logic [HIB_W-1:0] hib_pre;
  logic [OSC_W-1:0] osc_pre;
  logic [7:0] run_idle_cnt, rate_cnt;
  logic [12:0] frames_cnt;
  logic [15:0] osc_cnt;
  wire mode_change = (next_mode != mode);
  wire restart = motion_seen | mode_change | tracking_halt;
  wire sys_tick = (sys_pre == SYS_W'(SYS_TICK_CYCLES - 1));
  wire hib_tick = (hib_pre == HIB_W'(HIB_TICK_CYCLES - 1));
  wire osc_tick = (osc_pre == OSC_W'(OSC_DIV - 1));
  wire [7:0] active_rate = (mode == FIRST_LOW_POWER) ? first_low_power_state_frame_interval :
                           (mode == SECOND_LOW_POWER) ? second_low_power_state_frame_interval :
                           third_low_power_state_frame_interval;
  wire rest_frame = (mode != RUN_STATE) & hib_tick & (rate_cnt == active_rate);
  wire run_frame = (mode == RUN_STATE) & osc_tick & (osc_cnt + 16'h0001 >= frame_period);
  wire [12:0] limit1 = {1'b0, first_low_power_state_to_second_low_power_state_delay, 4'h0};
  wire [12:0] limit2 = {second_low_power_state_to_third_low_power_state_delay, 5'h00};
  wire run_due = (run_idle_cnt >= run_to_first_low_power_state_delay);
  wire [15:0] clamped = (auto_frame_period > active_bound) ? active_bound : auto_frame_period;

  // mode sequence: down in order while idle, back to run on motion
  always_comb begin
    next_mode = mode;
    unique case (mode)
      RUN_STATE: if (rest_enable && !motion_seen && !tracking_halt && run_due)
        next_mode = FIRST_LOW_POWER;
      FIRST_LOW_POWER: if (frames_cnt >= limit1) next_mode = SECOND_LOW_POWER;
      SECOND_LOW_POWER: if (frames_cnt >= limit2) next_mode = THIRD_LOW_POWER;
      THIRD_LOW_POWER: next_mode = THIRD_LOW_POWER;
    endcase
    if (mode != RUN_STATE && (motion_seen || !rest_enable)) next_mode = RUN_STATE;
  end

  // system and hibernate prescalers restart on motion, mode change or crc halt
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_pre <= '0;
      hib_pre <= '0;
      osc_pre <= '0;
    end else if (clk_en) begin
      sys_pre <= (restart || sys_tick) ? '0 : sys_pre + SYS_W'(1);
      hib_pre <= (restart || hib_tick) ? '0 : hib_pre + HIB_W'(1);
      osc_pre <= osc_tick ? '0 : osc_pre + OSC_W'(1);
    end
  end

  // mode and idle counters
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= RUN_STATE;
      run_idle_cnt <= 8'h00;
      rate_cnt <= 8'h00;
      frames_cnt <= 13'h0000;
    end else if (clk_en) begin
      mode <= next_mode;
      if (restart) begin
        run_idle_cnt <= 8'h00;
        rate_cnt <= 8'h00;
        frames_cnt <= 13'h0000;
      end else begin
        if (sys_tick && !run_due) run_idle_cnt <= run_idle_cnt + 8'h01;
        if (rest_frame) rate_cnt <= 8'h00;
        else if (hib_tick) rate_cnt <= rate_cnt + 8'h01;
        if (rest_frame && frames_cnt != 13'h1FFF) frames_cnt <= frames_cnt + 13'h0001;
      end
    end
  end

  // frame pacing and period selection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt <= 16'h0000;
      frame_strobe <= 1'b0;
      frame_period <= {RST_PERIOD_HIGH, RST_PERIOD_LOW};
      op_mode <= RUN_STATE;
      bound_settling <= 1'b0;
    end else if (clk_en) begin
      frame_period <= fixed_frame_rate_sel ? active_bound : clamped;
      if (mode != RUN_STATE || run_frame) osc_cnt <= 16'h0000;
      else if (osc_tick) osc_cnt <= osc_cnt + 16'h0001;
      frame_strobe <= ~tracking_halt & (run_frame | rest_frame);
      op_mode <= mode;
      bound_settling <= high_wr | (settle_cnt != 2'h0);
    end
  end

  // ==========================================================
  // checks
  default clocking chk_clk @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  crc_start_a: assert property (clk_en && crc_start |=> crc_busy && tracking_halt)
    else $error("crc test did not start");
  crc_result_a: assert property ($fell(crc_busy) |-> crc_result == crc_acc)
    else $error("crc result not published");
  halt_quiet_a: assert property (tracking_halt |=> !frame_strobe)
    else $error("frame taken during crc test");
  run_shift_a: assert property ($past(mode) == RUN_STATE && mode == FIRST_LOW_POWER
    |-> $past(run_idle_cnt) >= $past(run_to_first_low_power_state_delay) && !$past(motion_seen))
    else $error("run left before delay");
  rest_pace_a: assert property (rest_frame && clk_en |-> rate_cnt == active_rate ##1 frame_strobe)
    else $error("rest frame mistimed");
  second_low_power_state_shift_a: assert property ($past(mode) == FIRST_LOW_POWER && mode == SECOND_LOW_POWER
    |-> $past(frames_cnt) >= $past(limit1))
    else $error("first_low_power_state left early");
  third_low_power_state_shift_a: assert property ($past(mode) == SECOND_LOW_POWER && mode == THIRD_LOW_POWER
    |-> $past(frames_cnt) >= $past(limit2))
    else $error("second_low_power_state left early");
  motion_wake_a: assert property (clk_en && motion_seen && mode != RUN_STATE |=> mode == RUN_STATE)
    else $error("motion did not wake run");
  bound_load_a: assert property (clk_en && high_wr
    |=> active_bound == {$past(req.wdata), $past(longest_frame_period_low)} && bound_settling)
    else $error("bound not activated");
  fixed_period_a: assert property (clk_en && fixed_frame_rate_sel |=> frame_period == $past(active_bound))
    else $error("fixed period wrong");
  auto_limit_a: assert property (clk_en && !fixed_frame_rate_sel |=> frame_period <= $past(active_bound))
    else $error("auto period above bound");
  idle_restart_a: assert property (clk_en && motion_seen |=> run_idle_cnt == 8'h00 && frames_cnt == 13'h0000)
    else $error("timers not restarted");
endmodule // rmdt_top
`default_nettype wire

// ### tb/rmdt_host.sv
// Purpose: serial host model for the register port
// Assumes: mode 3, half period of five core cycles, pins moved at falling core edges
// Notes: mosi shows the inverse of its last bit while the port is deselected
`timescale 1ns/100ps
`default_nettype none
module rmdt_host (
  // clock
  input wire logic core_clk,
  // serial pins
  output logic ncs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  // ==========================================================
  // idle levels
  initial begin
    ncs_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
  end
  // one half period of the serial clock
  task automatic half();
    repeat (5) @(negedge core_clk);
  endtask
  // ==========================================================
  // address byte then data byte; read bits are taken at each rising sclk of the data byte
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] sh;
    sh = {a, d};
    q = 8'h00;
    ncs_n = 1'b0;
    half();
    for (int i = 15; i >= 0; i--) begin
      if (i == 7) half(); // extra gap before the first data falling edge
      sclk = 1'b0;
      mosi = sh[i];
      half();
      sclk = 1'b1;
      if (i < 8) q[i] = miso;
      half();
    end
    ncs_n = 1'b1;
    mosi = ~mosi;
    repeat (10) @(negedge core_clk);
  endtask
endmodule // rmdt_host
`default_nettype wire

// ### tb/tb_rmdt_top.sv
// Purpose: self-checking bench for the rest mode downshift timing block
// Assumes: ten-cycle ticks and a sixteen byte firmware memory
// Notes: expected crc is worked out here from the memory pattern
`timescale 1ns/100ps
`default_nettype none
module tb_rmdt_top;
  import rmdt_pkg::*;
  // ==========================================================
  // signals
  logic core_clk, reset_n, motion_seen, rest_enable, fixed_frame_rate_sel;
  logic clk_en, halt_q, fw_rd_q;
  logic ncs_n, sclk, mosi, miso, miso_oe, frame_strobe, bound_settling, tracking_halt, fw_rd;
  logic [15:0] auto_frame_period, frame_period, fw_addr, fw_addr_q;
  logic [7:0] fw_data, q;
  rmdt_mode_t op_mode;
  int fail_count, total_checks, cyc, halt_cyc, halt_frames, oe_cyc;
  rmdt_top #(.SYS_TICK_CYCLES(10), .HIB_TICK_CYCLES(10), .FW_BYTES(16)) rmdt_top_i (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .ncs_n(ncs_n), .sclk(sclk),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .motion_seen(motion_seen),
    .rest_enable(rest_enable), .fixed_frame_rate_sel(fixed_frame_rate_sel),
    .auto_frame_period(auto_frame_period), .op_mode(op_mode), .frame_strobe(frame_strobe),
    .frame_period(frame_period), .bound_settling(bound_settling),
    .tracking_halt(tracking_halt), .fw_addr(fw_addr), .fw_rd(fw_rd), .fw_data(fw_data));
  rmdt_host rmdt_host_i (.core_clk(core_clk), .ncs_n(ncs_n), .sclk(sclk), .mosi(mosi),
    .miso(miso));
  // clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // firmware memory pattern: read taken at one rising edge, data stands at the next
  function automatic logic [7:0] fwb(input logic [15:0] a);
    return a[7:0] * 8'h07 + 8'h03;
  endfunction
  always @(negedge core_clk) begin
    if (fw_rd_q) fw_data <= fwb(fw_addr_q);
  end
  // cycle, halt, suppressed frame and output enable counters; memory request capture
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (tracking_halt) halt_cyc <= halt_cyc + 1;
    if (halt_q && frame_strobe) halt_frames <= halt_frames + 1;
    if (miso_oe) oe_cyc <= oe_cyc + 1;
    halt_q <= tracking_halt;
    fw_rd_q <= fw_rd;
    fw_addr_q <= fw_addr;
  end
  // ==========================================================
  // shared helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic near(input int n, input int e, input int tol);
    chk(16'(n >= e - tol && n <= e + tol), 16'h0001);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    rmdt_host_i.xfer({1'b1, a}, d, q);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    rmdt_host_i.xfer({1'b0, a}, 8'h00, d);
  endtask
  task automatic wait_mode(input rmdt_mode_t m);
    for (int i = 0; i < 2000 && op_mode !== m; i++) @(negedge core_clk);
  endtask
  // cycles between two frame strobes
  task automatic gap(input int exp);
    int t;
    for (int i = 0; i < 400 && frame_strobe !== 1'b1; i++) @(negedge core_clk);
    t = cyc;
    @(negedge core_clk);
    for (int i = 0; i < 400 && frame_strobe !== 1'b1; i++) @(negedge core_clk);
    chk(16'(cyc - t), 16'(exp));
  endtask
  function automatic logic [15:0] crc_of(input int n);
    logic [15:0] c;
    c = 16'h0000;
    for (int k = 0; k < n; k++) begin
      c = c ^ {fwb(16'(k)), 8'h00};
      for (int b = 0; b < 8; b++) c = c[15] ? (c << 1) ^ 16'h1021 : c << 1;
    end
    return c;
  endfunction
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] e [8];
    logic [7:0] d;
    e = '{RST_RUN_DELAY, RST_FIRST_LOW_POWER_STATE_FRAME_INTERVAL, RST_FIRST_LOW_POWER_STATE_DELAY, RST_SECOND_LOW_POWER_STATE_FRAME_INTERVAL,
      RST_SECOND_LOW_POWER_STATE_DELAY, RST_THIRD_LOW_POWER_STATE_FRAME_INTERVAL, RST_PERIOD_LOW, RST_PERIOD_HIGH};
    chk(op_mode, RUN_STATE);
    chk(frame_period, 16'h5DC0);
    for (int i = 7; i >= 0; i--) begin
      rd(ADDR_RUN_DELAY + 7'(i), d);
      chk(d, e[i]);
    end
  endtask
  task automatic t_access();
    logic [7:0] d;
    int t;
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_RUN_DELAY + 7'(i), 8'hA0 + 8'(i));
      rd(ADDR_RUN_DELAY + 7'(i), d);
      chk(d, 8'hA0 + 8'(i));
    end
    wr(7'h30, 8'hAA);
    t = oe_cyc;
    rd(7'h30, d);
    chk(d, RD_ZERO);
    near(oe_cyc - t, 170, 2);
    rd(ADDR_FW_ENABLE, d);
    chk(d, RD_ZERO);
  endtask
  task automatic t_bound();
    logic [7:0] d;
    fixed_frame_rate_sel = 1'b1;
    wr(ADDR_PERIOD_LOW, 8'h10);
    chk(bound_settling, 1'b0);
    wr(ADDR_PERIOD_HIGH, 8'h00);
    chk(bound_settling, 1'b1);
    for (int i = 0; i < 60000 && bound_settling !== 1'b0; i++) @(negedge core_clk);
    chk(frame_period, 16'h0010);
    gap(32);
    fixed_frame_rate_sel = 1'b0;
    auto_frame_period = 16'h0008;
    repeat (2) @(negedge core_clk);
    chk(frame_period, 16'h0008);
    auto_frame_period = 16'h0100;
    repeat (2) @(negedge core_clk);
    chk(frame_period, 16'h0010);
    rd(ADDR_PERIOD_HIGH, d);
    chk(d, 8'h00);
    rd(ADDR_PERIOD_LOW, d);
    chk(d, 8'h10);
  endtask
  task automatic t_modes();
    int t;
    rest_enable = 1'b1;
    wr(ADDR_RUN_DELAY, 8'h03);
    wr(ADDR_FIRST_LOW_POWER_STATE_FRAME_INTERVAL, 8'h00);
    wr(ADDR_FIRST_LOW_POWER_STATE_DELAY, 8'h01);
    wr(ADDR_SECOND_LOW_POWER_STATE_FRAME_INTERVAL, 8'h01);
    wr(ADDR_SECOND_LOW_POWER_STATE_DELAY, 8'h01);
    wr(ADDR_THIRD_LOW_POWER_STATE_FRAME_INTERVAL, 8'h02);
    motion_seen = 1'b0;
    t = cyc;
    wait_mode(FIRST_LOW_POWER);
    near(cyc - t, 30, 11);
    t = cyc;
    gap(10);
    wait_mode(SECOND_LOW_POWER);
    near(cyc - t, 160, 11);
    t = cyc;
    gap(20);
    wait_mode(THIRD_LOW_POWER);
    near(cyc - t, 640, 21);
    gap(30);
    clk_en = 1'b0;
    motion_seen = 1'b1;
    repeat (5) @(negedge core_clk);
    chk(op_mode, THIRD_LOW_POWER);
    clk_en = 1'b1;
    repeat (2) @(negedge core_clk);
    chk(op_mode, RUN_STATE);
    motion_seen = 1'b0;
    t = cyc;
    wait_mode(FIRST_LOW_POWER);
    near(cyc - t, 30, 11);
    motion_seen = 1'b1;
    rest_enable = 1'b0;
  endtask
  task automatic t_crc();
    logic [7:0] lo, hi;
    chk(tracking_halt, 1'b0);
    wr(ADDR_FW_ENABLE, 8'h14);
    chk(16'(halt_cyc), 16'h0000);
    wr(ADDR_FW_ENABLE, CRC_START_CODE);
    for (int i = 0; i < 200 && (halt_cyc == 0 || tracking_halt !== 1'b0); i++) begin
      @(negedge core_clk);
    end
    near(halt_cyc, 20, 4);
    chk(16'(halt_frames), 16'h0000);
    rd(ADDR_CRC_LOW, lo);
    rd(ADDR_CRC_HIGH, hi);
    chk({hi, lo}, crc_of(16));
  endtask
  // ==========================================================
  // verdict
  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    reset_n = 1'b0;
    motion_seen = 1'b1;
    rest_enable = 1'b0;
    fixed_frame_rate_sel = 1'b1;
    clk_en = 1'b1;
    auto_frame_period = 16'h0100;
    fw_data = 8'h00;
    cyc = 0;
    oe_cyc = 0;
    halt_cyc = 0;
    halt_frames = 0;
    fail_count = 0;
    total_checks = 0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    repeat (6) @(negedge core_clk);
    t_reset();
    t_access();
    t_bound();
    t_modes();
    t_crc();
    tally_and_finish();
  end
  // watchdog
  initial begin
    #300000;
    fail_count++;
    tally_and_finish();
  end
endmodule // tb_rmdt_top
`default_nettype wire
